// ==== fbls_core.v ====
`timescale 1ns/1ps
`include "fbls_regs.vh"
module fbls_core #(
  parameter ADDR_W = 24,
  parameter [7:0] SUSPEND_OPCODE = 8'hB0,
  parameter PSL_CYC = (`FBLS_PSL_NS * (`FBLS_CLK_KHZ / 1000) + 999) / 1000,
  parameter ESL_CYC = (`FBLS_ESL_NS * (`FBLS_CLK_KHZ / 1000) + 999) / 1000
) (
  input wire I_CLOCK,
  input wire I_RST_B,
  input wire I_CE,
  input wire I_SCLK,
  input wire I_CS_B,
  input wire [3:0] I_SIO,
  input wire I_WP_B,
  input wire I_FOUR_LINE_MODE,
  input wire I_BLOCK_PROTECT_MODE,
  input wire I_PERF_ENHANCE,
  input wire I_OP_START,
  input wire I_OP_IS_ERASE,
  input wire [1:0] I_OP_SIZE,
  input wire [ADDR_W-1:0] I_OP_ADDR,
  input wire I_OP_DONE,
  input wire [ADDR_W-1:0] I_READ_ADDR,
  output reg [3:0] O_SIO,
  output reg [3:0] O_SIO_OE,
  output reg O_CMD_VALID,
  output reg [7:0] O_CMD_OPCODE,
  output reg O_WRITE_ENABLE_LATCH,
  output reg O_BUSY_FLAG,
  output reg O_PROGRAM_SUSPENDED_FLAG,
  output reg O_ERASE_SUSPENDED_FLAG,
  output wire [7:0] O_SECURITY_BITS,
  output wire O_ENGINE_HOLD,
  output reg O_READ_PERMITTED
);
  localparam NBLK = 1 << (ADDR_W - 16);
  localparam ST_IDLE = 5'h01;
  localparam ST_RUN = 5'h02;
  localparam ST_PAUSING = 5'h04;
  localparam ST_SUSP = 5'h08;
  localparam ST_NESTED = 5'h10;
  localparam [15:0] PSL_LOAD = PSL_CYC[15:0];
  localparam [15:0] ESL_LOAD = ESL_CYC[15:0];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg sclk_m, sclk_s, sclk_d;
  reg cs_m, cs_s, cs_d;
  reg [3:0] sio_m, sio_s;
  reg wp_m, wp_s;
  always @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      sio_m <= 4'h0;
      sio_s <= 4'h0;
      wp_m <= 1'b0;
      wp_s <= 1'b0;
    end else if (I_CE) begin
      sclk_m <= I_SCLK;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      cs_m <= I_CS_B;
      cs_s <= cs_m;
      cs_d <= cs_s;
      sio_m <= I_SIO;
      sio_s <= sio_m;
      wp_m <= I_WP_B;
      wp_s <= wp_m;
    end
  end
  wire sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  wire sclk_fall = ~sclk_s & sclk_d & ~cs_s;
  wire cs_rise = cs_s & ~cs_d;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Commands usable before the suspend latency has elapsed
  function early_ok;
    input [7:0] op;
    input erase;
    begin
      early_ok = (op == `FBLS_OP_STATUS_RD) || (op == `FBLS_OP_SECURITY_RD) ||
                 (op == `FBLS_OP_SIG) || (op == `FBLS_OP_RESET_ARM) ||
                 (op == `FBLS_OP_RST) || (op == `FBLS_OP_NOP) ||
                 (erase && op == `FBLS_OP_CLR_LATCH) ||
                 (!erase && op == `FBLS_OP_CONFIG_RD);
    end
  endfunction

  // Commands usable only once the suspend latency has elapsed
  function late_ok;
    input [7:0] op;
    input erase;
    begin
      late_ok = (op == `FBLS_OP_RD_SLOW) || (op == `FBLS_OP_RD_FAST) ||
                (op == `FBLS_OP_RD_DUAL_OUT) || (op == `FBLS_OP_RD_QUAD_OUT) ||
                (op == `FBLS_OP_RD_DUAL_IO) || (op == `FBLS_OP_RD_QUAD_IO) ||
                (op == `FBLS_OP_RD_QUAD_WORD) || (op == `FBLS_OP_RD_PARAM) ||
                (op == `FBLS_OP_QUERY) || (op == `FBLS_OP_ID_JEDEC) ||
                (op == `FBLS_OP_ID_FOUR) || (op == `FBLS_OP_ID_MAKER) ||
                (op == `FBLS_OP_SECURE_IN) || (op == `FBLS_OP_SECURE_OUT) ||
                (op == `FBLS_OP_FOUR_IN) || (op == `FBLS_OP_FOUR_OUT) ||
                (op == `FBLS_OP_RESUME) || (op == `FBLS_OP_BURST_SET);
      if (erase && (op == `FBLS_OP_SET_LATCH || op == `FBLS_OP_PP || op == `FBLS_OP_PP4))
        late_ok = 1'b1;
    end
  endfunction

  function [ADDR_W-1:0] size_mask;
    input [1:0] size;
    begin
      case (size)
        `FBLS_SIZE_PAGE: size_mask = {ADDR_W{1'b1}} << `FBLS_SHIFT_PAGE;
        `FBLS_SIZE_4K: size_mask = {ADDR_W{1'b1}} << `FBLS_SHIFT_4K;
        `FBLS_SIZE_32K: size_mask = {ADDR_W{1'b1}} << `FBLS_SHIFT_32K;
        default: size_mask = {ADDR_W{1'b1}} << `FBLS_SHIFT_64K;
      endcase
    end
  endfunction

  // ****************************************
  // Serial receive
  // ****************************************
  reg [31:0] shreg;
  reg [5:0] bitcnt;
  reg [7:0] opcode;
  reg [4:0] state;
  reg susp_erase;
  wire [5:0] step = I_FOUR_LINE_MODE ? 6'h04 : 6'h01;
  wire [31:0] next_shreg = I_FOUR_LINE_MODE ? {shreg[27:0], sio_s} :
                           {shreg[30:0], sio_s[0]};
  wire [6:0] cnt_sum = {1'b0, bitcnt} + {1'b0, step};
  wire [5:0] next_bitcnt = cnt_sum[6] ? `FBLS_BITS_MAX : cnt_sum[5:0];
  wire opcode_done = sclk_rise && next_bitcnt == `FBLS_BITS_OPCODE;
  wire addr_done = sclk_rise && next_bitcnt == `FBLS_BITS_ADDR;
  wire in_suspend = (state == ST_PAUSING) || (state == ST_SUSP) || (state == ST_NESTED);
  wire lat_done = (state == ST_SUSP);
  // Unlisted opcodes are dropped before any action; suspend state stays untouched
  wire cmd_ok = !in_suspend || early_ok(next_shreg[7:0], susp_erase) ||
                (lat_done && late_ok(next_shreg[7:0], susp_erase));
  reg cmd_taken;
  always @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      shreg <= 32'h0000_0000;
      bitcnt <= 6'h00;
      opcode <= 8'h00;
      cmd_taken <= 1'b0;
      O_CMD_VALID <= 1'b0;
      O_CMD_OPCODE <= 8'h00;
    end else if (I_CE) begin
      O_CMD_VALID <= 1'b0;
      if (cs_s) begin
        bitcnt <= 6'h00;
      end else if (sclk_rise) begin
        shreg <= next_shreg;
        bitcnt <= next_bitcnt;
        if (opcode_done) begin
          opcode <= next_shreg[7:0];
          cmd_taken <= cmd_ok;
          O_CMD_VALID <= cmd_ok;
          O_CMD_OPCODE <= next_shreg[7:0];
        end
      end
    end
  end
  // Actions fired on chip select rise exactly after one opcode byte
  wire exec = cs_rise && bitcnt == `FBLS_BITS_OPCODE && cmd_taken;

  // ****************************************
  // Lock bits
  // ****************************************
  // Sector granularity only in the first and last block, as is usual for such arrays
  // Volatile bits; reset stands in for power-up
  reg [NBLK-1:0] block_lock;
  reg [31:0] sector_lock;
  wire lock_cmd = exec && I_BLOCK_PROTECT_MODE && O_WRITE_ENABLE_LATCH &&
                  (opcode == `FBLS_OP_LOCK_ALL || opcode == `FBLS_OP_UNLOCK_ALL) &&
                  state == ST_IDLE;
  always @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      block_lock <= {NBLK{1'b1}};
      sector_lock <= 32'hFFFF_FFFF;
    end else if (I_CE && lock_cmd) begin
      block_lock <= {NBLK{opcode == `FBLS_OP_LOCK_ALL}};
      sector_lock <= {32{opcode == `FBLS_OP_LOCK_ALL}};
    end
  end
  wire [ADDR_W-17:0] q_blk = next_shreg[ADDR_W-1:16];
  wire [3:0] q_sec = next_shreg[15:12];
  wire q_edge = (q_blk == {(ADDR_W-16){1'b0}}) || (q_blk == {(ADDR_W-16){1'b1}});
  wire [4:0] q_sidx = {q_blk[0], q_sec};
  wire q_locked = !wp_s || (q_edge ? sector_lock[q_sidx] : block_lock[q_blk]);

  // ****************************************
  // Query answer
  // ****************************************
  reg [7:0] out_byte;
  reg [2:0] out_idx;
  reg answering;
  always @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      out_byte <= 8'h00;
      out_idx <= 3'h0;
      answering <= 1'b0;
      O_SIO <= 4'h0;
      O_SIO_OE <= 4'h0;
    end else if (I_CE) begin
      if (cs_s) begin
        answering <= 1'b0;
        O_SIO_OE <= 4'h0;
      end else if (addr_done && opcode == `FBLS_OP_QUERY && cmd_taken &&
                   I_BLOCK_PROTECT_MODE) begin
        answering <= 1'b1;
        out_byte <= {7'h00, q_locked};
        out_idx <= 3'h7;
      end else if (answering && sclk_fall) begin
        if (I_FOUR_LINE_MODE) begin
          O_SIO <= out_idx[2] ? out_byte[7:4] : out_byte[3:0];
          O_SIO_OE <= 4'hF;
          out_idx <= out_idx ^ 3'h4;
        end else begin
          O_SIO <= {2'h0, out_byte[out_idx], 1'b0};
          O_SIO_OE <= 4'h2;
          out_idx <= out_idx - 3'h1;
        end
      end
    end
  end

  // ****************************************
  // Operation, suspend and resume
  // ****************************************
  reg [15:0] lat_cnt;
  reg [ADDR_W-1:0] susp_addr;
  reg [1:0] susp_size;
  wire is_exec_op = exec;
  always @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state <= ST_IDLE;
      susp_erase <= 1'b0;
      lat_cnt <= 16'h0000;
      susp_addr <= {ADDR_W{1'b0}};
      susp_size <= `FBLS_SIZE_PAGE;
      O_WRITE_ENABLE_LATCH <= 1'b0;
      O_BUSY_FLAG <= 1'b0;
      O_PROGRAM_SUSPENDED_FLAG <= 1'b0;
      O_ERASE_SUSPENDED_FLAG <= 1'b0;
    end else if (I_CE) begin
      // Latch writes first; state transitions below override them where needed
      // One opcode per frame, so set and clear of the latch never collide
      if (is_exec_op && opcode == `FBLS_OP_SET_LATCH)
        O_WRITE_ENABLE_LATCH <= 1'b1;
      if (is_exec_op && opcode == `FBLS_OP_CLR_LATCH && state != ST_NESTED)
        O_WRITE_ENABLE_LATCH <= 1'b0;
      if (lock_cmd)
        O_WRITE_ENABLE_LATCH <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (I_OP_START) begin
            state <= ST_RUN;
            susp_erase <= I_OP_IS_ERASE;
            susp_addr <= I_OP_ADDR;
            susp_size <= I_OP_SIZE;
            O_BUSY_FLAG <= 1'b1;
          end
        end
        ST_RUN: begin
          if (I_OP_DONE) begin
            state <= ST_IDLE;
            O_BUSY_FLAG <= 1'b0;
            O_WRITE_ENABLE_LATCH <= 1'b0;
          end else if (is_exec_op && opcode == SUSPEND_OPCODE) begin
            state <= ST_PAUSING;
            lat_cnt <= susp_erase ? ESL_LOAD : PSL_LOAD;
          end
        end
        ST_PAUSING: begin
          if (I_OP_DONE) begin
            // Operation beat the suspend; nothing left to pause
            state <= ST_IDLE;
            O_BUSY_FLAG <= 1'b0;
            O_WRITE_ENABLE_LATCH <= 1'b0;
          end else if (lat_cnt <= 16'h0001) begin
            state <= ST_SUSP;
            O_BUSY_FLAG <= 1'b0;
            O_WRITE_ENABLE_LATCH <= 1'b0;
            O_PROGRAM_SUSPENDED_FLAG <= ~susp_erase;
            O_ERASE_SUSPENDED_FLAG <= susp_erase;
          end else begin
            lat_cnt <= lat_cnt - 16'h0001;
          end
        end
        ST_SUSP: begin
          if (is_exec_op && opcode == `FBLS_OP_RESUME && !I_PERF_ENHANCE) begin
            state <= ST_RUN;
            O_WRITE_ENABLE_LATCH <= 1'b1;
            O_BUSY_FLAG <= 1'b1;
            O_PROGRAM_SUSPENDED_FLAG <= 1'b0;
            O_ERASE_SUSPENDED_FLAG <= 1'b0;
          end else if (I_OP_START && susp_erase && O_WRITE_ENABLE_LATCH &&
                       ((I_OP_ADDR & size_mask(susp_size)) !=
                        (susp_addr & size_mask(susp_size)))) begin
            state <= ST_NESTED;
            O_BUSY_FLAG <= 1'b1;
          end
        end
        ST_NESTED: begin
          // Suspend and resume are not acted on here; the program must finish first
          if (I_OP_DONE) begin
            state <= ST_SUSP;
            O_BUSY_FLAG <= 1'b0;
            O_WRITE_ENABLE_LATCH <= 1'b0;
          end else begin
            O_WRITE_ENABLE_LATCH <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign O_ENGINE_HOLD = (state == ST_PAUSING) || (state == ST_SUSP) || (state == ST_NESTED);
  assign O_SECURITY_BITS = {I_BLOCK_PROTECT_MODE, 3'h0, O_ERASE_SUSPENDED_FLAG,
                            O_PROGRAM_SUSPENDED_FLAG, 2'h0};

  // ****************************************
  // Array read guard
  // ****************************************
  always @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_READ_PERMITTED <= 1'b0;
    end else if (I_CE) begin
      O_READ_PERMITTED <= (state == ST_IDLE) || ((state == ST_SUSP) &&
        ((I_READ_ADDR & size_mask(susp_size)) !=
         (susp_addr & size_mask(susp_size))));
    end
  end
endmodule

// ==== fbls_host.sv ====
`timescale 1ns/1ps
// ****************
// Host side of the serial bus
// ****************
module fbls_host (
  input wire i_clk,
  input wire [3:0] i_sio,
  output logic o_sclk,
  output logic o_cs_b,
  output logic [3:0] o_sio
);
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_sio = 4'h0;
  end
  // Serial clock idles low between frames, four cycles per phase
  task automatic frame(input logic [31:0] w, input int n, input logic q, input int rd,
                       output logic [7:0] rb);
    int s;
    s = q ? 4 : 1;
    rb = 8'h00;
    o_cs_b <= 1'b0;
    for (int i = 0; i < n + rd; i += s) begin
      if (i < n) o_sio <= q ? w[31-i -: 4] : {3'($urandom), w[31-i]};
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      if (i >= n) rb = q ? {rb[3:0], i_sio} : {rb[6:0], i_sio[1]};
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_cs_b <= 1'b1;
    // Released lines flip so a stale bit is never mistaken for data
    o_sio <= ~o_sio;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// ==== fbls_properties.sv ====
`timescale 1ns/1ps
// ****************
// Suspend and lock checker
// ****************
module fbls_checker #(
  parameter PSL_CYC = 800,
  parameter ESL_CYC = 800
) (
  input wire I_CLOCK,
  input wire I_RST_B,
  input wire I_CS_B,
  input wire I_BLOCK_PROTECT_MODE,
  input wire I_PERF_ENHANCE,
  input wire [3:0] O_SIO_OE,
  input wire O_CMD_VALID,
  input wire [7:0] O_CMD_OPCODE,
  input wire O_WRITE_ENABLE_LATCH,
  input wire O_BUSY_FLAG,
  input wire O_PROGRAM_SUSPENDED_FLAG,
  input wire O_ERASE_SUSPENDED_FLAG,
  input wire [7:0] O_SECURITY_BITS,
  input wire O_ENGINE_HOLD
);
  // Slack of three cycles covers the hold register and flag update
  localparam int LMAX = ((PSL_CYC > ESL_CYC) ? PSL_CYC : ESL_CYC) + 3;
  wire prog_s = O_PROGRAM_SUSPENDED_FLAG;
  wire erase_s = O_ERASE_SUSPENDED_FLAG;
  wire latch = O_WRITE_ENABLE_LATCH;
  wire busy = O_BUSY_FLAG;
  wire susp = prog_s | erase_s;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  AST_LAT_MIN: assert property ($rose(O_ENGINE_HOLD) |-> (!susp) [*3])
    else $error("suspend flag before latency");
  AST_LAT_MAX: assert property ($rose(O_ENGINE_HOLD) |-> ##[1:LMAX] susp)
    else $error("suspend flag late");
  AST_SUSP_LATCH: assert property ($rose(susp) |-> !latch && !busy)
    else $error("latch kept on suspend");
  AST_SEC_FLAGS: assert property (O_SECURITY_BITS[3:2] == {erase_s, prog_s})
    else $error("security flags wrong");
  AST_RESUME: assert property ($fell(susp) |-> latch && busy)
    else $error("resume left latch or busy low");
  AST_PROG_NO_LATCH: assert property (prog_s |-> !latch)
    else $error("latch set in program suspend");
  AST_PROG_FILTER: assert property (prog_s && O_CMD_VALID |->
    !(O_CMD_OPCODE inside {8'h06, 8'h02, 8'h38, 8'h04})) else $error("refused op taken");
  AST_ERASE_FILTER: assert property (erase_s && O_CMD_VALID |-> O_CMD_OPCODE != 8'h15)
    else $error("config read taken in erase suspend");
  AST_NESTED: assert property (erase_s && busy |-> latch)
    else $error("nested program without latch");
  AST_PERF: assert property (I_PERF_ENHANCE && susp |=> susp)
    else $error("resume taken in enhance mode");
  AST_RELEASE: assert property (I_CS_B [*5] |-> O_SIO_OE == 4'h0)
    else $error("output kept after deselect");
  AST_MODE_OFF: assert property (!I_BLOCK_PROTECT_MODE &&
    !$past(I_BLOCK_PROTECT_MODE) |-> O_SIO_OE == 4'h0) else $error("query answered");
endmodule
bind fbls_core fbls_checker #(.PSL_CYC(PSL_CYC), .ESL_CYC(ESL_CYC)) chk (
  .I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_CS_B(I_CS_B),
  .I_BLOCK_PROTECT_MODE(I_BLOCK_PROTECT_MODE), .I_PERF_ENHANCE(I_PERF_ENHANCE),
  .O_SIO_OE(O_SIO_OE), .O_CMD_VALID(O_CMD_VALID), .O_CMD_OPCODE(O_CMD_OPCODE),
  .O_WRITE_ENABLE_LATCH(O_WRITE_ENABLE_LATCH), .O_BUSY_FLAG(O_BUSY_FLAG),
  .O_PROGRAM_SUSPENDED_FLAG(O_PROGRAM_SUSPENDED_FLAG),
  .O_ERASE_SUSPENDED_FLAG(O_ERASE_SUSPENDED_FLAG), .O_SECURITY_BITS(O_SECURITY_BITS),
  .O_ENGINE_HOLD(O_ENGINE_HOLD));

// ==== fbls_regs.vh ====
// Notes on behaviour
// - Lock-status query works only in per-block protection mode; otherwise ignored.
// - Query: opcode 3Ch, 3 address bytes, status byte repeats until chip select rises.
// - Address bits top to 16 pick a 64K block, top to 12 a 4K sector.
// - Status bit reads 1 for a protected region, 0 for a writable one.
// - Opcodes come in 8 clocks on one line or 2 clocks on four lines.
// - After write enable, opcode 7Eh alone locks all, 98h alone unlocks all.
// - Whole-chip lock and unlock are ignored outside per-block protection mode.
// - Whole-chip lock and unlock need chip select to rise on a byte boundary.
// - Suspend interrupts a running page program, sector erase or block erase.
// - While suspended, reads are refused only inside the suspended page or region; the code refuses every read while a nested program runs.
// - After suspend latency, write latch clears and the matching suspend flag sets.
// - After latency both suspend types accept reads, query, ids, modes, resume.
// - Erase suspend alone also accepts write enable and both page program opcodes.
// - Status, security, signature, reset, no-op accepted at once in any suspend.
// - Security bit 2 shows program suspend, bit 3 erase suspend.
// - Inside erase suspend, page program of unprotected memory is allowed.
// - A program started inside erase suspend cannot itself be suspended.
// - That nested program holds latch and busy at 1, clears both when done.
// - Resume sets latch and busy at once, clears the suspend flag, continues.
// - Resume is ignored in continuous-read performance-enhance mode.
// - Every lock bit is set to 1 at power-up.
// - With write-protect pin low, every region reads as protected.
`ifndef FBLS_REGS_VH
`define FBLS_REGS_VH
`define FBLS_OP_QUERY 8'h3C
`define FBLS_OP_LOCK_ALL 8'h7E
`define FBLS_OP_UNLOCK_ALL 8'h98
`define FBLS_OP_RESUME 8'h30
`define FBLS_OP_SET_LATCH 8'h06
`define FBLS_OP_CLR_LATCH 8'h04
`define FBLS_OP_PP 8'h02
`define FBLS_OP_PP4 8'h38
`define FBLS_OP_STATUS_RD 8'h05
`define FBLS_OP_CONFIG_RD 8'h15
`define FBLS_OP_SECURITY_RD 8'h2B
`define FBLS_OP_SIG 8'hAB
`define FBLS_OP_RESET_ARM 8'h66
`define FBLS_OP_RD_SLOW 8'h03
`define FBLS_OP_RD_FAST 8'h0B
`define FBLS_OP_RD_DUAL_OUT 8'h3B
`define FBLS_OP_RD_QUAD_OUT 8'h6B
`define FBLS_OP_RD_DUAL_IO 8'hBB
`define FBLS_OP_RD_QUAD_IO 8'hEB
`define FBLS_OP_RD_QUAD_WORD 8'hE7
`define FBLS_OP_RD_PARAM 8'h5A
`define FBLS_OP_ID_JEDEC 8'h9F
`define FBLS_OP_ID_FOUR 8'hAF
`define FBLS_OP_ID_MAKER 8'h90
`define FBLS_OP_SECURE_IN 8'hB1
`define FBLS_OP_SECURE_OUT 8'hC1
`define FBLS_OP_FOUR_IN 8'h35
`define FBLS_OP_FOUR_OUT 8'hF5
`define FBLS_OP_BURST_SET 8'hC0
`define FBLS_OP_RST 8'h99
`define FBLS_OP_NOP 8'h00
`define FBLS_BITS_OPCODE 6'h08
`define FBLS_BITS_ADDR 6'h20
`define FBLS_BITS_MAX 6'h3F
`define FBLS_SIZE_PAGE 2'h0
`define FBLS_SIZE_4K 2'h1
`define FBLS_SIZE_32K 2'h2
`define FBLS_SIZE_64K 2'h3
`define FBLS_SHIFT_PAGE 8
`define FBLS_SHIFT_4K 12
`define FBLS_SHIFT_32K 15
`define FBLS_SHIFT_64K 16
`define FBLS_SEC_PROG_SUSP 2
`define FBLS_SEC_ERASE_SUSP 3
`define FBLS_SEC_MODE 7
`define FBLS_CLK_KHZ 40000
`define FBLS_PSL_NS 20000
`define FBLS_ESL_NS 20000
`endif

// ==== fbls_tb.sv ====
`timescale 1ns/1ps
// ****************
// Bench for block lock and suspend
// ****************
module tb;
  localparam logic [7:0] SUSP = 8'hB0;
  logic clk, rst_b, wp_b, quad, bpm, perf, op_start, op_er, op_done;
  logic [1:0] op_size;
  logic [23:0] op_addr, rd_addr, a;
  logic [7:0] rb;
  wire sclk, cs_b, cv, latch, busy, prog_s, erase_s, hold, rp;
  wire [3:0] sio, so, so_oe;
  // Undriven lines read as pulled up, so a stale output bit cannot pass as data
  wire [3:0] sin = (so & so_oe) | ~so_oe;
  wire [7:0] cop, sec;
  int err_count, cmp_count, nvalid, n0;
  int shv[4] = '{8, 12, 15, 16};
  logic [7:0] ops[20] = '{8'h03, 8'hEB, 8'h5A, 8'h3C, 8'h9F, 8'hB1, 8'hC1, 8'h35, 8'hF5,
    8'hC0, 8'h05, 8'h15, 8'h2B, 8'hAB, 8'h66, 8'h00, 8'h06, 8'h02, 8'h38, 8'h04};
  fbls_core #(.PSL_CYC(4), .ESL_CYC(4), .SUSPEND_OPCODE(SUSP)) uut (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_SCLK(sclk), .I_CS_B(cs_b), .I_SIO(sio),
    .I_WP_B(wp_b), .I_FOUR_LINE_MODE(quad), .I_BLOCK_PROTECT_MODE(bpm),
    .I_PERF_ENHANCE(perf), .I_OP_START(op_start), .I_OP_IS_ERASE(op_er),
    .I_OP_SIZE(op_size), .I_OP_ADDR(op_addr), .I_OP_DONE(op_done), .I_READ_ADDR(rd_addr),
    .O_SIO(so), .O_SIO_OE(so_oe), .O_CMD_VALID(cv), .O_CMD_OPCODE(cop),
    .O_WRITE_ENABLE_LATCH(latch), .O_BUSY_FLAG(busy), .O_PROGRAM_SUSPENDED_FLAG(prog_s),
    .O_ERASE_SUSPENDED_FLAG(erase_s), .O_SECURITY_BITS(sec), .O_ENGINE_HOLD(hold),
    .O_READ_PERMITTED(rp));
  fbls_host host (.i_clk(clk), .i_sio(sin), .o_sclk(sclk), .o_cs_b(cs_b), .o_sio(sio));
  always @(posedge clk) if (cv === 1'b1) nvalid++;
  function automatic logic [7:0] lk(input logic locked);
    return {7'h00, locked | !wp_b};
  endfunction
  function automatic logic [7:0] acc(input logic [7:0] op, input logic er);
    if (op == 8'h15) return {7'h00, !er};
    if (op inside {8'h06, 8'h02, 8'h38, 8'h04}) return {7'h00, er};
    return 8'h01;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame({op, 24'h0}, 8, quad, 0, rb);
  endtask
  task automatic qchk(input logic locked);
    quad <= 1'($urandom);
    a = 24'($urandom);
    @(posedge clk);
    host.frame({8'h3C, a}, 32, quad, 8, rb);
    chk(rb, lk(locked));
  endtask
  task automatic pulse_op(input logic er, input logic [1:0] sz, input logic [23:0] ad);
    op_er <= er;
    op_size <= sz;
    op_addr <= ad;
    op_start <= 1'b1;
    @(posedge clk);
    op_start <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic done_op;
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run is about 2700 to 8100 cycles, set by the random line mode
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    {rst_b, quad, perf, op_start, op_er, op_done} = '0;
    {op_size, op_addr, rd_addr} = '0;
    wp_b = 1'b1;
    bpm = 1'b1;
    void'($urandom(32'hB6F5));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk(8'({prog_s, erase_s, latch, busy}), 8'h00);
    repeat (4) qchk(1'b1);
    cmd(8'h06);
    cmd(8'h98);
    qchk(1'b0);
    wp_b <= 1'b0;
    qchk(1'b1);
    wp_b <= 1'b1;
    cmd(8'h06);
    host.frame({8'h7E, 24'h0}, 9, quad, 0, rb);
    qchk(1'b0);
    bpm <= 1'b0;
    cmd(8'h06);
    cmd(8'h7E);
    host.frame({8'h3C, 24'h0}, 32, quad, 8, rb);
    chk(rb, 8'hFF);
    bpm <= 1'b1;
    qchk(1'b0);
    cmd(8'h06);
    cmd(8'h7E);
    qchk(1'b1);
    cmd(8'h06);
    cmd(8'h98);
    for (int s = 0; s < 4; s++) begin
      a = 24'($urandom);
      pulse_op(s != 0, 2'(s), a);
      cmd(SUSP);
      repeat (8) @(posedge clk);
      chk(8'({sec[3:2], latch, busy, hold}), s != 0 ? 8'h11 : 8'h09);
      rd_addr <= a ^ 24'($urandom % (1 << shv[s]));
      repeat (2) @(posedge clk);
      chk(8'(rp), 8'h00);
      rd_addr <= a ^ (24'h1 << shv[s]);
      repeat (2) @(posedge clk);
      chk(8'(rp), 8'h01);
      if (s < 2) begin
        foreach (ops[k]) begin
          n0 = nvalid;
          cmd(ops[k]);
          chk(8'(nvalid - n0), acc(ops[k], s == 1));
        end
        chk(8'({sec[3:2], latch}), s != 0 ? 8'h04 : 8'h02);
      end
      if (s == 1) begin
        cmd(8'h06);
        pulse_op(1'b0, 2'h0, a ^ 24'h2000);
        chk(8'({latch, busy, erase_s}), 8'h07);
        cmd(SUSP);
        repeat (8) @(posedge clk);
        chk(8'({latch, busy, erase_s}), 8'h07);
        done_op();
        chk(8'({latch, busy, erase_s}), 8'h01);
        perf <= 1'b1;
        cmd(8'h30);
        perf <= 1'b0;
        chk(8'(erase_s), 8'h01);
      end
      cmd(8'h30);
      chk(8'({sec[3:2], latch, busy}), 8'h03);
      done_op();
      chk(8'(busy), 8'h00);
    end
    conclude();
  end
endmodule
